// ==== core/dqc_core.sv ====
// Two-channel 24-bit up/down counter with command/data byte ports
`timescale 1ns/100ps
`include "dqc_map.svh"

// Operation
// - Command byte first, then its data bytes
// - Codes 100/101/110: quadrature, async clear, 1/2/4x
// - Format one, any code: up/down, sync clear
// - Codes 011/111: gated pulse, async clear
// - Direction bit swaps up and down
// - Quadrature; A rise with B low, direction zero, counts down
// - Up/down pulses; simultaneous pulses not counted
// - Gated: count only while B high
// - Sync clear on A rise, B low, index
// - Async clear on index, restart on A rise
// - Polarity bit one: index active low
// - Up/down mode ignores multiplier setting
// - Index mode: ignore, once, every; reset once
// - Run bit low re-arms once-only clear
// - Active-low match while count equals compare
// - Compare written low, middle, high bytes
// - Filter needs four equal samples; gp bypasses
// - Four-bit code selects sample period
// - Latch bits copy counts, both at once
// - Mask bits one suppress interrupts
// - Run bit zero holds counter at zero
// - Polarity bit selects index active level
// - Codes 000/001/010: quadrature, sync clear
module dqc_core
  import dqc_pkg::*;
#(
  parameter int unsigned FLT_W1_CYC = `DQC_FLT_W1_NS / `DQC_CLK_NS,
  parameter int unsigned FLT_W2_CYC = `DQC_FLT_W2_NS / `DQC_CLK_NS,
  parameter int unsigned FLT_W3_CYC = `DQC_FLT_W3_NS / `DQC_CLK_NS
)(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Host byte ports
  input wire logic cmd_wr_i,
  input wire logic dat_wr_i,
  input wire logic dat_rd_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  // Encoder inputs, bit n is channel n
  input wire logic [1:0] phase_a_i,
  input wire logic [1:0] phase_b_i,
  input wire logic [1:0] index_i,
  input wire logic [1:0] gp_i,
  // Status outputs
  output logic [1:0] match_status_n_o,
  output logic irq_o
);
  // Sampling period in cycles, never under one
  localparam int unsigned FLT_BASE_CYC = `DQC_FLT_BASE_NS / `DQC_CLK_NS;
  localparam int unsigned FLT_W0_CYC = `DQC_FLT_W0_NS / `DQC_CLK_NS;

  // ****************************************
  // State
  // ****************************************
  logic [7:0] cmd_q, cmd_d; // Current command
  logic [1:0] idx_q, idx_d; // Byte position in a 24-bit transfer
  logic [2:0] mask_q, mask_d; // Timer, ch1, ch0 masks
  logic [7:0] rdata_q, rdata_d; // Read port byte
  logic irq_q, irq_d; // Unmasked match present
  logic [1:0][23:0] cnt_q, cnt_d; // Live counters
  logic [1:0][23:0] cmp_q, cmp_d; // Compare values
  logic [1:0][23:0] rdr_q, rdr_d; // Latched counts
  logic [1:0][23:0] pre_q, pre_d; // Preload staging
  logic [1:0][7:0] mode_q, mode_d; // Mode bytes
  logic [1:0][1:0] zcm_q, zcm_d; // Index clear modes
  logic [1:0][3:0] flt_q, flt_d; // Filter clock codes
  logic [1:0][19:0] div_q, div_d; // Sample dividers
  logic [1:0] tick_q, tick_d; // Sample strobes
  logic [1:0] ap_q, ap_d; // Previous filtered A
  logic [1:0] bp_q, bp_d; // Previous filtered B
  logic [1:0] zp_q, zp_d; // Previous filtered index
  logic [1:0] hold_q, hold_d; // Held at zero after a clear
  logic [1:0] fired_q, fired_d; // Once-only clear used
  logic [1:0] ai_q, ai_d; // Abnormal input seen
  logic [1:0] down_q, down_d; // Last step was down
  logic [1:0] mtn_q, mtn_d; // Match, active low
  // Per-channel decode, also watched by the checks
  logic [5:0] filt; // A0 A1 B0 B1 Z0 Z1 after filtering
  logic [1:0] ar_w, up_w, dn_w, clra_w, zact_w, gate_w, quad_w, updn_w;

  // ****************************************
  // Input filters
  // ****************************************
  // Only A, B and index go through; gp is read raw
  for (genvar g = 0; g < 6; g++)
  begin : g_flt
    dqc_filter u_flt (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .sample_i(tick_q[g % 2]),
      .raw_i(g < 2 ? phase_a_i[g % 2] : (g < 4 ? phase_b_i[g % 2] : index_i[g % 2])),
      .filt_o(filt[g])
    );
  end

  // ****************************************
  // Host writes and counting
  // ****************************************
  always_comb
  begin
    logic fa, fb, fz, ar, af, br, bf, zact, zactp, run, dir, async_m, zen;
    logic fw, rv, abn, ld, rel;
    logic [2:0] code;
    logic [19:0] per;
    dqc_fmt_e fmt;
    dqc_mult_e mult;
    fa = 1'b0; fb = 1'b0; fz = 1'b0; ar = 1'b0; af = 1'b0; br = 1'b0; bf = 1'b0;
    zact = 1'b0; zactp = 1'b0; run = 1'b0; dir = 1'b0; async_m = 1'b0; zen = 1'b0;
    fw = 1'b0; rv = 1'b0; abn = 1'b0; ld = 1'b0; rel = 1'b0;
    code = 3'h0; per = 20'h00000; fmt = DQC_QUAD; mult = DQC_X1;
    cmd_d = cmd_q; idx_d = idx_q; mask_d = mask_q; irq_d = irq_q;
    cnt_d = cnt_q; cmp_d = cmp_q; rdr_d = rdr_q; pre_d = pre_q;
    mode_d = mode_q; zcm_d = zcm_q; flt_d = flt_q; div_d = div_q; tick_d = tick_q;
    ap_d = ap_q; bp_d = bp_q; zp_d = zp_q; hold_d = hold_q; fired_d = fired_q;
    ai_d = ai_q; down_d = down_q; mtn_d = mtn_q;
    ar_w = 2'h0; up_w = 2'h0; dn_w = 2'h0; clra_w = 2'h0;
    zact_w = 2'h0; gate_w = 2'h0; quad_w = 2'h0; updn_w = 2'h0;
    // Command byte restarts the byte sequence
    if (cmd_wr_i)
    begin
      cmd_d = host_wdata_i;
      idx_d = 2'h0;
    end
    else if (dat_wr_i || dat_rd_i)
    begin
      idx_d = (idx_q == 2'h2) ? 2'h0 : idx_q + 2'h1;
    end
    if (dat_wr_i && cmd_q == `DQC_CMD_MASK)
    begin
      mask_d = {host_wdata_i[4], host_wdata_i[1:0]};
    end
    for (int c = 0; c < 2; c++)
    begin
      // Per-channel events start clear so one channel never inherits the other's
      fw = 1'b0;
      rv = 1'b0;
      ld = 1'b0;
      fa = filt[c];
      fb = filt[2 + c];
      fz = filt[4 + c];
      ar = fa & ~ap_q[c];
      af = ~fa & ap_q[c];
      br = fb & ~bp_q[c];
      bf = ~fb & bp_q[c];
      run = mode_q[c][`DQC_MODE_RUN_BIT];
      dir = mode_q[c][`DQC_MODE_DIR_BIT];
      code = mode_q[c][2:0];
      // Index active level follows the polarity bit
      zact = fz ^ mode_q[c][`DQC_MODE_ZPOL_BIT];
      zactp = zp_q[c] ^ mode_q[c][`DQC_MODE_ZPOL_BIT];
      // Mode decode; format one is always single-edge up/down
      if (mode_q[c][`DQC_MODE_FMT_BIT])
      begin
        fmt = DQC_UPDN;
        mult = DQC_X1;
        async_m = 1'b0;
      end
      else if (code[1:0] == 2'b11)
      begin
        fmt = DQC_GATE;
        mult = code[2] ? DQC_X2 : DQC_X1;
        async_m = 1'b1;
      end
      else
      begin
        fmt = DQC_QUAD;
        mult = (code[1:0] == 2'b00) ? DQC_X1 : ((code[1:0] == 2'b01) ? DQC_X2 : DQC_X4);
        async_m = code[2];
      end
      // Forward and reverse events before the direction swap
      unique case (fmt)
        DQC_QUAD:
        begin
          abn = (ar | af) & (br | bf); // Both phases moved in one sample
          if (!abn)
          begin
            fw = (ar & ~fb) | (mult != DQC_X1 & af & fb);
            rv = (af & ~fb) | (mult != DQC_X1 & ar & fb);
            if (mult == DQC_X4)
            begin
              fw = fw | (br & fa) | (bf & ~fa);
              rv = rv | (br & ~fa) | (bf & fa);
            end
          end
        end
        DQC_UPDN:
        begin
          abn = ar & br;
          fw = ar & ~br;
          rv = br & ~ar;
        end
        default:
        begin
          abn = 1'b0;
          fw = fb & (ar | (mult == DQC_X2 & af));
          rv = 1'b0;
        end
      endcase
      // Direction zero makes forward a down count
      up_w[c] = run & (dir ? fw : rv);
      dn_w[c] = run & (dir ? rv : fw);
      ar_w[c] = ar;
      zact_w[c] = zact;
      gate_w[c] = (fmt == DQC_GATE);
      quad_w[c] = (fmt == DQC_QUAD);
      updn_w[c] = (fmt == DQC_UPDN);
      // Index clear enable: 01 off, 10 once, 11 always
      zen = (zcm_q[c] == 2'b11) | (zcm_q[c] == 2'b10 & ~fired_q[c]);
      clra_w[c] = run & zen & (async_m ? (zact & ~zactp) : (ar & ~fb & zact));
      // Counting resumes on an A rise; sync mode waits for index to go inactive
      rel = ar & (async_m | ~zact);
      // Host data bytes for this channel
      if (dat_wr_i)
      begin
        if (cmd_q == 8'(`DQC_CMD_PRELOAD + c * `DQC_CH_STRIDE))
        begin
          unique case (idx_q)
            2'h0: pre_d[c][7:0] = host_wdata_i;
            2'h1: pre_d[c][15:8] = host_wdata_i;
            default: pre_d[c][23:16] = host_wdata_i;
          endcase
          ld = (idx_q == 2'h2);
        end
        if (cmd_q == 8'(`DQC_CMD_MODE + c * `DQC_CH_STRIDE))
        begin
          mode_d[c] = host_wdata_i;
        end
        if (cmd_q == 8'(`DQC_CMD_ZCLR + c * `DQC_CH_STRIDE))
        begin
          zcm_d[c] = host_wdata_i[2:1];
        end
        if (cmd_q == 8'(`DQC_CMD_CMP + c * `DQC_CH_STRIDE))
        begin
          unique case (idx_q)
            2'h0: cmp_d[c][7:0] = host_wdata_i;
            2'h1: cmp_d[c][15:8] = host_wdata_i;
            default: cmp_d[c][23:16] = host_wdata_i;
          endcase
        end
        if (cmd_q == 8'(`DQC_CMD_FLT + c * `DQC_CH_STRIDE))
        begin
          flt_d[c] = host_wdata_i[3:0];
        end
        // One write latches every channel whose bit is set, on the same edge
        if (cmd_q == `DQC_CMD_LATCH && host_wdata_i[c])
        begin
          rdr_d[c] = cnt_q[c];
        end
      end
      // Counter update, highest priority first
      if (!run)
      begin
        cnt_d[c] = 24'h000000;
        hold_d[c] = 1'b0;
        fired_d[c] = 1'b0;
      end
      else if (ld)
      begin
        cnt_d[c] = {host_wdata_i, pre_q[c][15:0]};
        hold_d[c] = 1'b0;
      end
      else if (clra_w[c])
      begin
        cnt_d[c] = 24'h000000;
        hold_d[c] = 1'b1;
        fired_d[c] = fired_q[c] | (zcm_q[c] == 2'b10);
      end
      else if (!hold_q[c] || rel)
      begin
        hold_d[c] = 1'b0;
        // Natural 24-bit wrap in both directions
        if (up_w[c])
        begin
          cnt_d[c] = cnt_q[c] + 24'h000001;
        end
        else if (dn_w[c])
        begin
          cnt_d[c] = cnt_q[c] - 24'h000001;
        end
      end
      if (up_w[c] || dn_w[c])
      begin
        down_d[c] = dn_w[c];
      end
      // Abnormal flag: a new event beats the read that clears it
      if (dat_rd_i && cmd_q == 8'(`DQC_CMD_MODE + c * `DQC_CH_STRIDE))
      begin
        ai_d[c] = 1'b0;
      end
      if (abn)
      begin
        ai_d[c] = 1'b1;
      end
      mtn_d[c] = ~(cnt_q[c] == cmp_q[c]);
      ap_d[c] = fa;
      bp_d[c] = fb;
      zp_d[c] = fz;
      // Sample divider; code bits add fixed weights to the base period
      per = 20'(FLT_BASE_CYC) + (flt_q[c][0] ? 20'(FLT_W0_CYC) : 20'h00000)
          + (flt_q[c][1] ? 20'(FLT_W1_CYC) : 20'h00000) + (flt_q[c][2] ? 20'(FLT_W2_CYC) : 20'h00000)
          + (flt_q[c][3] ? 20'(FLT_W3_CYC) : 20'h00000);
      tick_d[c] = (div_q[c] >= per - 20'h00001);
      div_d[c] = tick_d[c] ? 20'h00000 : div_q[c] + 20'h00001;
    end
    // Interrupt request for unmasked matches only
    irq_d = |(~mtn_q & ~mask_q[1:0]);
  end

  // ****************************************
  // Read port
  // ****************************************
  // Byte for the current command and position, one cycle behind
  always_comb
  begin
    rdata_d = 8'h00;
    if (cmd_q == `DQC_CMD_MASK)
    begin
      rdata_d = {3'h0, mask_q[2], 2'h0, mask_q[1:0]};
    end
    for (int c = 0; c < 2; c++)
    begin
      if (cmd_q == 8'(`DQC_CMD_PRELOAD + c * `DQC_CH_STRIDE))
      begin
        unique case (idx_q)
          2'h0: rdata_d = rdr_q[c][7:0];
          2'h1: rdata_d = rdr_q[c][15:8];
          default: rdata_d = rdr_q[c][23:16];
        endcase
      end
      if (cmd_q == 8'(`DQC_CMD_MODE + c * `DQC_CH_STRIDE))
      begin
        rdata_d = {ai_q[c], zact_w[c], filt[c], filt[2 + c], 1'b1, down_q[c], mtn_q[c], gp_i[c]};
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmd_q <= 8'h00; idx_q <= 2'h0; mask_q <= `DQC_MASK_RST; rdata_q <= 8'h00; irq_q <= 1'b0;
      cnt_q <= '0; cmp_q <= {2{`DQC_CMP_RST}}; rdr_q <= '0; pre_q <= '0;
      mode_q <= {2{`DQC_MODE_RST}}; zcm_q <= {2{`DQC_ZCLR_RST}}; flt_q <= {2{`DQC_FLT_RST}};
      div_q <= '0; tick_q <= 2'h0; ap_q <= 2'h0; bp_q <= 2'h0; zp_q <= 2'h0;
      hold_q <= 2'h0; fired_q <= 2'h0; ai_q <= 2'h0; down_q <= 2'h0; mtn_q <= 2'h3;
    end
    else
    begin
      cmd_q <= cmd_d; idx_q <= idx_d; mask_q <= mask_d; rdata_q <= rdata_d; irq_q <= irq_d;
      cnt_q <= cnt_d; cmp_q <= cmp_d; rdr_q <= rdr_d; pre_q <= pre_d;
      mode_q <= mode_d; zcm_q <= zcm_d; flt_q <= flt_d;
      div_q <= div_d; tick_q <= tick_d; ap_q <= ap_d; bp_q <= bp_d; zp_q <= zp_d;
      hold_q <= hold_d; fired_q <= fired_d; ai_q <= ai_d; down_q <= down_d; mtn_q <= mtn_d;
    end
  end

  assign host_rdata_o = rdata_q;
  assign match_status_n_o = mtn_q;
  assign irq_o = irq_q;

  // ****************************************
  // Checks on channel 0
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_run_low_zero;
    !mode_q[0][`DQC_MODE_RUN_BIT] |=> cnt_q[0] == 24'h000000 && !fired_q[0];
  endproperty
  a_run_low_zero: assert property (p_run_low_zero) else $error("counter not held at zero");
  property p_match;
    (cnt_q[0] == cmp_q[0]) |=> !match_status_n_o[0];
  endproperty
  a_match: assert property (p_match) else $error("match flag wrong");
  // Request trails the match flag by one cycle, so look one cycle later
  property p_irq;
    !match_status_n_o[0] && !mask_q[0] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked match raised no request");
  property p_wrap;
    cnt_q[0] == 24'hFFFFFF && up_w[0] && !hold_q[0] && !clra_w[0] && !dat_wr_i |=> cnt_q[0] == 24'h000000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");
  property p_latch;
    dat_wr_i && cmd_q == `DQC_CMD_LATCH && host_wdata_i[0] |=> rdr_q[0] == $past(cnt_q[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("latch missed count");
  property p_async;
    clra_w[0] && !dat_wr_i |=> cnt_q[0] == 24'h000000 && hold_q[0];
  endproperty
  a_async: assert property (p_async) else $error("index clear failed");
  property p_gate;
    gate_w[0] && !filt[2] |-> !up_w[0] && !dn_w[0];
  endproperty
  a_gate: assert property (p_gate) else $error("gated count with gate low");
  property p_updn_both;
    updn_w[0] && ar_w[0] && filt[2] && !bp_q[0] |-> !up_w[0] && !dn_w[0];
  endproperty
  a_updn_both: assert property (p_updn_both) else $error("counted simultaneous pulses");
  property p_dir0;
    quad_w[0] && mode_q[0][`DQC_MODE_RUN_BIT] && !mode_q[0][`DQC_MODE_DIR_BIT] && ar_w[0] && !filt[2] && !bp_q[0]
      |-> dn_w[0] && !up_w[0];
  endproperty
  a_dir0: assert property (p_dir0) else $error("A rise did not count down");
  property p_filter;
    $changed(filt[0]) |-> $past(tick_q[0], 1) || $past(tick_q[0], 2) || $past(tick_q[0], 3);
  endproperty
  a_filter: assert property (p_filter) else $error("filter moved without samples");

  c_async_clear: cover property (clra_w[0] ##1 cnt_q[0] == 24'h000000);
  c_match: cover property ($fell(match_status_n_o[0]));
  c_wrap_down: cover property (cnt_q[0] == 24'h000000 && dn_w[0] ##1 cnt_q[0] == 24'hFFFFFF);
  c_irq: cover property ($rose(irq_o));
endmodule // dqc_core

// ==== core/dqc_filter.sv ====
// Four-sample majority-free noise filter for one encoder input
`timescale 1ns/100ps
module dqc_filter (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Sample strobe and raw level
  input wire logic sample_i,
  input wire logic raw_i,
  // Filtered level
  output logic filt_o
);
  logic [3:0] hist_q; // Last four samples
  logic [3:0] hist_d;
  logic filt_q; // Level passed on to the counter
  logic filt_d;

  // ****************************************
  // Sampling and agreement
  // ****************************************
  // A pulse shorter than four samples never gets through
  always_comb
  begin
    hist_d = hist_q;
    filt_d = filt_q;
    if (sample_i)
    begin
      hist_d = {hist_q[2:0], raw_i};
    end
    if (hist_q == 4'hF)
    begin
      filt_d = 1'b1;
    end
    else if (hist_q == 4'h0)
    begin
      filt_d = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hist_q <= 4'h0;
      filt_q <= 1'b0;
    end
    else
    begin
      hist_q <= hist_d;
      filt_q <= filt_d;
    end
  end

  assign filt_o = filt_q;
endmodule // dqc_filter

// ==== core/dqc_map.svh ====
// Command codes, field positions, reset values and timing for the counter core
`ifndef DQC_MAP_SVH
`define DQC_MAP_SVH
// Command codes (channel 1 adds the stride to the channel 0 code)
`define DQC_CMD_PRELOAD 8'h00
`define DQC_CMD_MODE 8'h01
`define DQC_CMD_ZCLR 8'h02
`define DQC_CMD_CMP 8'h03
`define DQC_CMD_FLT 8'h04
`define DQC_CH_STRIDE 8'h05
`define DQC_CMD_LATCH 8'h14
`define DQC_CMD_MASK 8'h15
// Mode byte fields
`define DQC_MODE_RUN_BIT 7
`define DQC_MODE_ZPOL_BIT 5
`define DQC_MODE_FMT_BIT 4
`define DQC_MODE_DIR_BIT 3
// Reset values
`define DQC_MODE_RST 8'h00
`define DQC_ZCLR_RST 2'h2
`define DQC_CMP_RST 24'h000000
`define DQC_FLT_RST 4'h0
`define DQC_MASK_RST 3'h7
// Sampling period: base plus one weight per code bit, in ns
`define DQC_CLK_NS 4
`define DQC_FLT_BASE_NS 100
`define DQC_FLT_W0_NS 6400
`define DQC_FLT_W1_NS 25600
`define DQC_FLT_W2_NS 204800
`define DQC_FLT_W3_NS 819200
`endif

// ==== core/dqc_pkg.sv ====
// Types shared by the counter core
package dqc_pkg;
  // Decoded counting format
  typedef enum logic [1:0] {
    DQC_QUAD = 2'b00,
    DQC_UPDN = 2'b01,
    DQC_GATE = 2'b10
  } dqc_fmt_e;
  // Edge multiplier
  typedef enum logic [1:0] {
    DQC_X1 = 2'b00,
    DQC_X2 = 2'b01,
    DQC_X4 = 2'b10
  } dqc_mult_e;
endpackage

// ==== tb/dqc_core_bench.sv ====
// Self-checking bench for the two-channel counter core
`timescale 1ns/100ps
`include "dqc_map.svh"
module dqc_core_bench;
  // Gap between encoder changes: four samples of 25 plus pipeline
  localparam int HOLD = 130;
  // Bench signals
  logic core_clk, rst_n, cmd_wr, dat_wr, dat_rd, irq, step, fwd, zreq;
  logic [7:0] wdata, rdata;
  logic [1:0] pa, pb, idx, gp, match_n;
  logic [23:0] got, e;
  int num_errors, total_checks;
  // Mode codes under test and their edge multipliers
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int mults [6] = '{1, 2, 4, 1, 2, 4};

  dqc_core dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .cmd_wr_i(cmd_wr), .dat_wr_i(dat_wr),
    .dat_rd_i(dat_rd), .host_wdata_i(wdata), .host_rdata_o(rdata), .phase_a_i(pa), .phase_b_i(pb),
    .index_i(idx), .gp_i(gp), .match_status_n_o(match_n), .irq_o(irq));
  dqc_encoder_model enc0 (.core_clk_i(core_clk), .rst_n_i(rst_n), .step_i(step), .fwd_i(fwd),
    .index_req_i(zreq), .phase_a_o(pa[0]), .phase_b_o(pb[0]), .index_o(idx[0]));
  // Second channel stays idle; only channel 0 is exercised
  assign pa[1] = 1'b0;
  assign pb[1] = 1'b0;
  assign idx[1] = 1'b0;

  // ****************
  // Host port tasks
  // ****************
  // One strobe cycle: command when c is 1, data byte otherwise
  task automatic put(input logic c, input logic [7:0] d);
    @(negedge core_clk);
    cmd_wr = c;
    dat_wr = !c;
    wdata = d;
    @(negedge core_clk);
    cmd_wr = 1'b0;
    dat_wr = 1'b0;
  endtask
  // Command then n reads, low byte first, an idle cycle after each
  task automatic rd(input logic [7:0] c, input int n, output logic [23:0] v);
    v = 24'h000000;
    put(1'b1, c);
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      dat_rd = 1'b1;
      v[8*i +: 8] = rdata;
      @(negedge core_clk);
      dat_rd = 1'b0;
    end
  endtask
  // Latch channel 0 then read its 24-bit count
  task automatic count(output logic [23:0] v);
    put(1'b1, `DQC_CMD_LATCH);
    put(1'b0, 8'h01);
    rd(`DQC_CMD_PRELOAD, 3, v);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    put(1'b1, c);
    put(1'b0, d);
  endtask
  // n quarter steps of the encoder, each given time to pass the filter at its reset period of 25 cycles
  task automatic move(input logic f, input int n);
    repeat (n)
    begin
      @(negedge core_clk);
      fwd = f;
      step = 1'b1;
      @(negedge core_clk);
      step = 1'b0;
      repeat (HOLD) @(negedge core_clk);
    end
  endtask
  task automatic check(input logic [23:0] g, input logic [23:0] x);
    total_checks++;
    if (g !== x)
      $display("Error at %0t: got %h expected %h", $time, g, x);
    if (g !== x)
      num_errors++;
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************
  // Clock, reset, watchdog
  // ****************
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Whole run is about 30k cycles; a hang is cut well after that
  initial
  begin
    repeat (80000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    {cmd_wr, dat_wr, dat_rd, step, fwd, zreq} = 6'h00;
    wdata = 8'h00;
    gp = 2'h0;
    num_errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    rd(`DQC_CMD_MASK, 1, got);
    check(got, 24'h000013);
    check({23'h0, match_n[0]}, 24'h0);
    // Every quadrature mode, both direction settings, A leading B
    for (int k = 0; k < 6; k++)
      for (int d = 0; d < 2; d++)
      begin
        wr(`DQC_CMD_MODE, {5'h00, codes[k]});
        wr(`DQC_CMD_MODE, {1'b1, 3'h0, d[0], codes[k]});
        move(1'b1, 8);
        count(got);
        e = 24'(2 * mults[k]);
        if (d == 0)
          e = -e;
        check(got, e);
      end
    // Count is now +8; compare still 0, then bytes low first
    check({23'h0, match_n[0]}, 24'h1);
    put(1'b1, `DQC_CMD_CMP);
    put(1'b0, 8'h08);
    put(1'b0, 8'h00);
    put(1'b0, 8'h00);
    repeat (3) @(negedge core_clk);
    check({22'h0, match_n[0], irq}, 24'h0);
    wr(`DQC_CMD_MASK, 8'h00);
    repeat (3) @(negedge core_clk);
    check({23'h0, irq}, 24'h1);
    // Run bit low holds the counter at zero despite steps
    wr(`DQC_CMD_MODE, 8'h04);
    move(1'b1, 4);
    count(got);
    check(got, 24'h000000);
    // Asynchronous clear on every index, restart on next A rise
    wr(`DQC_CMD_ZCLR, 8'h06);
    wr(`DQC_CMD_MODE, 8'h84);
    move(1'b1, 4);
    zreq = 1'b1;
    repeat (HOLD) @(negedge core_clk);
    count(got);
    check(got, 24'h000000);
    zreq = 1'b0;
    repeat (HOLD) @(negedge core_clk);
    move(1'b1, 4);
    count(got);
    check(got, 24'hFFFFFF);
    // Index clear disabled by the host: index now ignored
    wr(`DQC_CMD_ZCLR, 8'h02);
    zreq = 1'b1;
    repeat (HOLD) @(negedge core_clk);
    count(got);
    check(got, 24'hFFFFFF);
    zreq = 1'b0;
    repeat (HOLD) @(negedge core_clk);
    // Reverse quarter steps count up through the top of the range
    move(1'b0, 4);
    count(got);
    check(got, 24'h000000);
    // Once-only clear: first index clears, second is ignored, run low re-arms
    wr(`DQC_CMD_ZCLR, 8'h04);
    for (int r = 0; r < 3; r++)
    begin
      move(1'b1, 4);
      zreq = 1'b1;
      repeat (HOLD) @(negedge core_clk);
      count(got);
      check(got, r == 1 ? 24'hFFFFFF : 24'h000000);
      zreq = 1'b0;
      repeat (HOLD) @(negedge core_clk);
      if (r == 1)
      begin
        wr(`DQC_CMD_MODE, 8'h04);
        wr(`DQC_CMD_MODE, 8'h84);
      end
    end
    // Index active low, sync clear: A rise with B low clears while index is low
    wr(`DQC_CMD_ZCLR, 8'h06);
    wr(`DQC_CMD_MODE, 8'h20);
    wr(`DQC_CMD_MODE, 8'hA0);
    move(1'b1, 4);
    count(got);
    check(got, 24'h000000);
    zreq = 1'b1;
    repeat (HOLD) @(negedge core_clk);
    move(1'b1, 4);
    count(got);
    check(got, 24'hFFFFFF);
    zreq = 1'b0;
    repeat (HOLD) @(negedge core_clk);
    // Gated single-pulse: A rises with B low are held, with B high counted
    wr(`DQC_CMD_MODE, 8'h03);
    wr(`DQC_CMD_MODE, 8'h83);
    move(1'b1, 8);
    count(got);
    check(got, 24'h000000);
    move(1'b0, 8);
    count(got);
    check(got, 24'hFFFFFE);
    // Up/down pulses with a 4x code, direction one: a lone A rise counts one up
    wr(`DQC_CMD_MODE, 8'h10);
    wr(`DQC_CMD_MODE, 8'h9A);
    move(1'b1, 1);
    count(got);
    check(got, 24'h000001);
    // A longer sample period: the next step is not through after the short wait
    wr(`DQC_CMD_FLT, 8'h01);
    move(1'b1, 1);
    count(got);
    check(got, 24'h000001);
    repeat (6600) @(negedge core_clk);
    count(got);
    check(got, 24'h000000);
    end_of_test();
  end
endmodule // dqc_core_bench

// ==== tb/dqc_encoder_model.sv ====
// Behavioural quadrature encoder driving one counter channel
`timescale 1ns/100ps
module dqc_encoder_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Step request, its sense and index request
  input wire logic step_i,
  input wire logic fwd_i,
  input wire logic index_req_i,
  // Encoder outputs
  output logic phase_a_o,
  output logic phase_b_o,
  output logic index_o
);
  // ****************
  // Shaft position
  // ****************
  // Quarter-cycle position, Gray decoded below
  logic [1:0] pos_q;
  // One quarter step per request; forward lets A lead B
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pos_q <= 2'h0;
    else if (step_i)
      pos_q <= fwd_i ? pos_q + 2'h1 : pos_q - 2'h1;
  end
  // Only one line changes per step, so no step looks abnormal
  assign phase_a_o = pos_q[1] ^ pos_q[0];
  assign phase_b_o = pos_q[1];
  // Caller spaces every change beyond the filter span
  assign index_o = index_req_i;
endmodule // dqc_encoder_model
